// File: hdl/adcsc_pkg.sv
// adcsc_pkg: constants shared by the converter sequencing control.
// assumes a 25 MHz system clock; the converter clock is an enable pulse.
package adcsc_pkg;
   localparam int          DIV_RESET        = 8;     // system cycles per converter cycle
   localparam int          NORMAL_CYCLES    = 13;
   localparam int          FIRST_CYCLES     = 25;
   localparam int          NORMAL_SAMPLE    = 1;     // sample taken half a cycle later
   localparam int          FIRST_SAMPLE     = 13;
   localparam logic [9:0]  FULL_SCALE       = 10'h03FF;
   localparam logic [3:0]  CHAN_RESET       = 4'h0;
   localparam logic [1:0]  REF_RESET        = 2'h0;
   localparam logic [1:0]  REF_EXT_PIN      = 2'h0;
   localparam logic [1:0]  REF_SUPPLY       = 2'h1;
   localparam logic [1:0]  REF_RESERVED     = 2'h2;
   localparam logic [1:0]  REF_INTERNAL     = 2'h3;
   localparam logic [1:0]  SLEEP_NONE       = 2'h0;
   localparam logic [1:0]  SLEEP_IDLE       = 2'h1;
   localparam logic [1:0]  SLEEP_NOISE      = 2'h2;
   localparam logic [1:0]  SLEEP_OTHER      = 2'h3;
   typedef enum logic [1:0] {
      ADCSC_IDLE  = 2'b00,
      ADCSC_CONV  = 2'b01
   } adcsc_state_t;
endpackage : adcsc_pkg

// File: hdl/adcsc_clkdiv.sv
// adcsc_clkdiv: converter clock enable divider.
// assumes i_run low holds the divider in reset, as when the converter is off.
`timescale 1ns/1ns
module adcsc_clkdiv
   import adcsc_pkg::*;
#(
   parameter int DIV = DIV_RESET
) (
   input  wire logic i_clk_sys,
   input  wire logic i_sys_rst,
   input  wire logic i_run,
   output logic      o_tick
);
   initial begin
      if (DIV < 2 || DIV > 256) $error("adcsc_clkdiv: DIV out of range");
   end
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   always_comb begin
      next_cnt = cnt + 8'h01;
      if (!i_run || cnt == 8'(DIV - 1)) next_cnt = 8'h00;
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) cnt <= 8'h00;
      else cnt <= next_cnt;
   end
   assign o_tick = i_run && (cnt == 8'(DIV - 1));
endmodule : adcsc_clkdiv

// File: hdl/adcsc_top.sv
// adcsc_top: sequencing control for a successive-approximation converter.
// assumes software bits arrive as same-clock ports with one-cycle write strobes;
// the analog result and the sleep state come from logic on the same clock.
`timescale 1ns/1ns
// How it works
// - a normal conversion lasts 13 converter cycles, sample at 1.5.
// - the first conversion after enabling lasts 25 cycles, sample at 13.5.
// - selection sits in a temporary register; the working copy tracks it while idle.
// - the working selection freezes once a conversion starts.
// - tracking resumes in the last cycle before the done flag sets.
// - a start write begins the conversion on the next converter clock edge.
// - free running change after first completion shows in the result after next.
// - free running starts a new conversion at once, start bit staying set.
// - completion stores result and sets done; single mode clears start together.
// - inputs above the reference saturate at full scale.
// - reference field: 00 pin, 01 supply, 10 reserved, 11 internal.
// - noise canceler works only in noise-reduction and idle sleep.
// - halting in those sleep modes with the converter prepared starts a conversion.
// - the completion interrupt wakes the cpu when nothing else did.
// - an earlier wake still leaves the completion request raised at the end.
// - other sleep modes do not disable the converter.
module adcsc_top
   import adcsc_pkg::*;
#(
   parameter int DIV = DIV_RESET
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_sys_rst,
   input  wire logic       i_sel_wr,
   input  wire logic [3:0] i_channel_select_bits,
   input  wire logic [1:0] i_reference_select_bits,
   input  wire logic       i_converter_enable_bit,
   input  wire logic       i_free_running_bit,
   input  wire logic       i_start_wr,
   input  wire logic       i_done_clr,
   input  wire logic       i_irq_en,
   input  wire logic       i_cpu_halted,
   input  wire logic [1:0] i_sleep_mode,
   input  wire logic [9:0] i_analog_code,
   input  wire logic       i_over_ref,
   output logic [3:0]      o_channel_select_bits,
   output logic [1:0]      o_reference_select_bits,
   output logic [3:0]      o_work_channel,
   output logic [1:0]      o_work_reference,
   output logic            o_internal_ref_on,
   output logic            o_conversion_start_bit,
   output logic            o_conversion_done_flag,
   output logic            o_busy,
   output logic            o_sample,
   output logic [9:0]      o_result,
   output logic            o_irq
);
   initial begin
      if (DIV < 2 || DIV > 256) $error("adcsc_top: DIV out of range");
   end

   logic               tick;
   adcsc_state_t       state;
   adcsc_state_t       next_state;
   logic [4:0]         cyc;
   logic [4:0]         next_cyc;
   logic               first;
   logic               next_first;
   logic               start;
   logic               next_start;
   logic               done;
   logic               next_done;
   logic               sample;
   logic               next_sample;
   logic [3:0]         tmp_ch;
   logic [3:0]         next_tmp_ch;
   logic [1:0]         tmp_ref;
   logic [1:0]         next_tmp_ref;
   logic [3:0]         wch;
   logic [3:0]         next_wch;
   logic [1:0]         wref;
   logic [1:0]         next_wref;
   logic [9:0]         held;
   logic [9:0]         next_held;
   logic [9:0]         result;
   logic [9:0]         next_result;
   logic               sleep_armed;
   logic               next_sleep_armed;
   logic               last_cyc;
   logic               finish;
   logic               nc_mode;
   logic               nc_start;

   adcsc_clkdiv #(.DIV(DIV)) u_div (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_run     (i_converter_enable_bit),
      .o_tick    (tick)
   );

   function automatic logic [4:0] conv_len(input logic f);
      conv_len = f ? 5'(FIRST_CYCLES) : 5'(NORMAL_CYCLES);
   endfunction : conv_len

   // sleep modes other than these leave the converter alone
   assign nc_mode  = (i_sleep_mode == SLEEP_NOISE) || (i_sleep_mode == SLEEP_IDLE);
   // one start per halt: armed again only once the cpu wakes
   assign nc_start = nc_mode && i_cpu_halted && sleep_armed && i_converter_enable_bit
                     && !i_free_running_bit && !start && state == ADCSC_IDLE;
   assign last_cyc = (state == ADCSC_CONV) && (cyc == conv_len(first) - 5'd1);
   assign finish   = last_cyc && tick;

   always_comb begin
      next_state       = state;
      next_cyc         = cyc;
      next_first       = first;
      next_start       = start;
      next_done        = done;
      next_sample      = 1'b0;
      next_tmp_ch      = tmp_ch;
      next_tmp_ref     = tmp_ref;
      next_wch         = wch;
      next_wref        = wref;
      next_held        = held;
      next_result      = result;
      next_sleep_armed = sleep_armed;
      if (i_sel_wr) begin
         next_tmp_ch  = i_channel_select_bits;
         next_tmp_ref = i_reference_select_bits;
      end
      // working copy follows while idle and in the last cycle; frozen otherwise
      if (state == ADCSC_IDLE || last_cyc) begin
         next_wch  = tmp_ch;
         next_wref = tmp_ref;
      end
      if (!i_cpu_halted) next_sleep_armed = 1'b1;
      if (i_start_wr && i_converter_enable_bit) next_start = 1'b1;
      if (nc_start) begin
         next_start       = 1'b1;
         next_sleep_armed = 1'b0;
      end
      if (i_done_clr) next_done = 1'b0;
      case (state)
         ADCSC_IDLE: begin
            if (start && tick) begin
               next_state = ADCSC_CONV;
               next_cyc   = 5'd0;
            end
         end
         ADCSC_CONV: begin
            if (tick) begin
               next_cyc = cyc + 5'd1;
               if (cyc == (first ? 5'(FIRST_SAMPLE) : 5'(NORMAL_SAMPLE))) begin
                  next_sample = 1'b1;
                  next_held   = i_over_ref ? FULL_SCALE : i_analog_code;
               end
               if (last_cyc) begin
                  next_result = held;
                  next_done   = 1'b1;
                  next_first  = 1'b0;
                  if (i_free_running_bit) begin
                     next_cyc = 5'd0;
                  end else begin
                     next_state = ADCSC_IDLE;
                     next_start = 1'b0;
                  end
               end
            end
         end
         default: next_state = ADCSC_IDLE;
      endcase
      // disabling ends any conversion; next enable gives the long first one
      if (!i_converter_enable_bit) begin
         next_state = ADCSC_IDLE;
         next_start = 1'b0;
         next_first = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         state       <= ADCSC_IDLE;
         cyc         <= 5'd0;
         first       <= 1'b1;
         start       <= 1'b0;
         done        <= 1'b0;
         sample      <= 1'b0;
         tmp_ch      <= CHAN_RESET;
         tmp_ref     <= REF_RESET;
         wch         <= CHAN_RESET;
         wref        <= REF_RESET;
         held        <= 10'h0000;
         result      <= 10'h0000;
         sleep_armed <= 1'b1;
      end else begin
         state       <= next_state;
         cyc         <= next_cyc;
         first       <= next_first;
         start       <= next_start;
         done        <= next_done;
         sample      <= next_sample;
         tmp_ch      <= next_tmp_ch;
         tmp_ref     <= next_tmp_ref;
         wch         <= next_wch;
         wref        <= next_wref;
         held        <= next_held;
         result      <= next_result;
         sleep_armed <= next_sleep_armed;
      end
   end

   assign o_channel_select_bits   = tmp_ch;
   assign o_reference_select_bits = tmp_ref;
   assign o_work_channel          = wch;
   assign o_work_reference        = wref;
   // reserved code keeps the internal reference off
   assign o_internal_ref_on       = i_converter_enable_bit && (wref == REF_INTERNAL);
   assign o_conversion_start_bit  = start;
   assign o_conversion_done_flag  = done;
   assign o_busy                  = (state == ADCSC_CONV);
   assign o_sample                = sample;
   assign o_result                = result;
   assign o_irq                   = done && i_irq_en;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   // selection path: temporary register, working copy and readback
   sel_frozen_a: assert property (o_busy && !last_cyc && $past(o_busy) |-> $stable(wch))
      else $error("working channel changed during conversion");
   ref_frozen_a: assert property (o_busy && !last_cyc && $past(o_busy) |-> $stable(wref))
      else $error("working reference changed during conversion");
   sel_track_a: assert property (!o_busy && !$past(o_busy) && i_converter_enable_bit
                                 |-> wch == $past(tmp_ch))
      else $error("working channel not tracking");
   ref_track_a: assert property (!o_busy && !$past(o_busy) |-> wref == $past(tmp_ref))
      else $error("working reference not tracking");
   tmp_hold_a: assert property (!i_sel_wr |=> $stable(o_channel_select_bits))
      else $error("temporary selection changed without a write");
   readback_a: assert property (i_sel_wr
                                |=> o_channel_select_bits == $past(i_channel_select_bits))
      else $error("selection readback wrong");

   // conversion timing; the half-cycle sample lands one system cycle after its tick
   start_edge_a: assert property (state == ADCSC_IDLE && start && tick
                                  && i_converter_enable_bit |=> o_busy && cyc == 5'd0)
      else $error("conversion did not start on edge");
   idle_wait_a: assert property (state == ADCSC_IDLE && !tick |=> !o_busy)
      else $error("conversion started between converter edges");
   len_norm_a: assert property (o_busy && !first |-> cyc < 5'(NORMAL_CYCLES))
      else $error("normal conversion too long");
   len_first_a: assert property (o_busy && first |-> cyc < 5'(FIRST_CYCLES))
      else $error("first conversion too long");
   sample_norm_a: assert property (tick && o_busy && !first
                                   && cyc == 5'(NORMAL_SAMPLE) |=> o_sample)
      else $error("normal sample pulse missing");
   sample_first_a: assert property (tick && o_busy && first
                                    && cyc == 5'(FIRST_SAMPLE) |=> o_sample)
      else $error("first sample pulse missing");
   sample_once_a: assert property (o_sample |=> !o_sample)
      else $error("sample pulse longer than one cycle");
   saturate_a: assert property (o_busy && tick && i_over_ref && !first
                                && cyc == 5'(NORMAL_SAMPLE) |=> held == FULL_SCALE)
      else $error("over-reference input did not saturate");

   // completion: flag, start bit, interrupt and result
   done_set_a: assert property (finish && i_converter_enable_bit |=> done)
      else $error("done flag not set on completion");
   single_clr_a: assert property (finish && !i_free_running_bit |=> !start && !o_busy)
      else $error("start bit not cleared in single mode");
   free_run_a: assert property (finish && i_free_running_bit && i_converter_enable_bit
                                |=> o_busy && start && cyc == 5'd0)
      else $error("free running did not restart");
   done_hold_a: assert property (done && !i_done_clr |=> done)
      else $error("done flag dropped without a clear");
   first_clear_a: assert property (finish |=> !first)
      else $error("long first conversion repeated");
   off_abort_a: assert property (!i_converter_enable_bit |=> !o_busy && !start && first)
      else $error("disable did not end the conversion");
   irq_raise_a: assert property (finish |=> o_irq == i_irq_en)
      else $error("completion interrupt missing");
   result_hold_a: assert property (!finish |=> $stable(o_result))
      else $error("result changed outside completion");

   // noise canceler start
   nc_go_a: assert property (nc_start && i_converter_enable_bit |=> start)
      else $error("noise canceler did not request conversion");
   nc_once_a: assert property (nc_start |=> !nc_start)
      else $error("noise canceler started twice in one halt");
   other_sleep_a: assert property (i_sleep_mode == SLEEP_OTHER && i_cpu_halted && !start
                                   && !i_start_wr |=> !start)
      else $error("conversion started in wrong sleep mode");

   // main scenarios
   c_single_c: cover property (finish && !i_free_running_bit && !first);
   c_first_c:  cover property (finish && first);
   c_free_c:   cover property (finish && i_free_running_bit);
   c_nc_c:     cover property (nc_start);
   c_resel_c:  cover property (last_cyc && tmp_ch != wch);
endmodule : adcsc_top

// File: bench/adcsc_analog_model.sv
// adcsc_analog_model: analog input channels and reference source facing the converter.
// assumes the working selection outputs of adcsc_top drive it directly.
`timescale 1ns/1ns
module adcsc_analog_model (
   input  wire logic [3:0] i_work_channel,
   input  wire logic [1:0] i_work_reference,
   output logic [9:0]      o_analog_code,
   output logic            o_over_ref
);
   // the code carries channel and reference, so a stale selection shows in the result
   assign o_analog_code = {i_work_reference, 4'h5, i_work_channel};
   // channel 13 carries a level above any reference
   assign o_over_ref    = (i_work_channel == 4'hD);
   // nothing fixed drives the reference pin, so every reference option may be chosen
endmodule : adcsc_analog_model

// File: bench/adcsc_top_test.sv
// adcsc_top_test: self-checking bench for the converter sequencing control.
// assumes adcsc_top with a short divider; inputs change on the falling clock edge.
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module adcsc_top_test;
   import adcsc_pkg::*;
   localparam int DIV = 2;
   logic       i_clk_sys, i_sys_rst, i_sel_wr, i_converter_enable_bit, i_free_running_bit;
   logic       i_start_wr, i_done_clr, i_irq_en, i_cpu_halted, i_over_ref;
   logic [3:0] i_channel_select_bits, o_channel_select_bits, o_work_channel;
   logic [1:0] i_reference_select_bits, i_sleep_mode, o_reference_select_bits, o_work_reference;
   logic [9:0] i_analog_code, o_result;
   logic       o_internal_ref_on, o_conversion_start_bit, o_conversion_done_flag;
   logic       o_busy, o_sample, o_irq;
   int         n_mismatch, n_tests, cyc;
   adcsc_top #(.DIV(DIV)) u_adcsc_top (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .i_sel_wr(i_sel_wr), .i_channel_select_bits(i_channel_select_bits),
      .i_reference_select_bits(i_reference_select_bits),
      .i_converter_enable_bit(i_converter_enable_bit), .i_free_running_bit(i_free_running_bit),
      .i_start_wr(i_start_wr), .i_done_clr(i_done_clr), .i_irq_en(i_irq_en),
      .i_cpu_halted(i_cpu_halted), .i_sleep_mode(i_sleep_mode), .i_analog_code(i_analog_code),
      .i_over_ref(i_over_ref), .o_channel_select_bits(o_channel_select_bits),
      .o_reference_select_bits(o_reference_select_bits), .o_work_channel(o_work_channel),
      .o_work_reference(o_work_reference), .o_internal_ref_on(o_internal_ref_on),
      .o_conversion_start_bit(o_conversion_start_bit),
      .o_conversion_done_flag(o_conversion_done_flag), .o_busy(o_busy), .o_sample(o_sample),
      .o_result(o_result), .o_irq(o_irq));
   adcsc_analog_model u_adcsc_analog_model (.i_work_channel(o_work_channel),
      .i_work_reference(o_work_reference), .o_analog_code(i_analog_code),
      .o_over_ref(i_over_ref));
   function automatic logic [9:0] exp_code(input logic [3:0] ch, input logic [1:0] rf);
      exp_code = (ch == 4'hD) ? FULL_SCALE : {rf, 4'h5, ch};
   endfunction : exp_code
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task automatic wr_sel(input logic [3:0] ch, input logic [1:0] rf);
      @(negedge i_clk_sys);
      i_sel_wr = 1'b1;
      i_channel_select_bits = ch;
      i_reference_select_bits = rf;
      @(negedge i_clk_sys);
      i_sel_wr = 1'b0;
   endtask : wr_sel
   task automatic start;
      @(negedge i_clk_sys);
      i_start_wr = 1'b1;
      @(negedge i_clk_sys);
      i_start_wr = 1'b0;
   endtask : start
   task automatic clr;
      @(negedge i_clk_sys);
      i_done_clr = 1'b1;
      @(negedge i_clk_sys);
      i_done_clr = 1'b0;
   endtask : clr
   // bounded waits: a stuck design runs into the comparisons, not into a hang
   task automatic wait_done;
      for (int i = 0; i < 64 * DIV && o_conversion_done_flag !== 1'b1; i++) @(negedge i_clk_sys);
   endtask : wait_done
   task automatic wait_idle;
      for (int i = 0; i < 64 * DIV && o_busy !== 1'b0; i++) @(negedge i_clk_sys);
   endtask : wait_idle
   // counts the cycles with busy high and where the sample pulse fell among them
   task automatic measure(input int len, input int smp);
      int n;
      int s;
      n = 0;
      s = -1;
      for (int i = 0; i < DIV + 2 && o_busy !== 1'b1; i++) @(negedge i_clk_sys);
      `CHK(o_busy, 1'b1);
      while (o_busy === 1'b1 && n < 64 * DIV) begin
         if (o_sample === 1'b1) s = n;
         n++;
         @(negedge i_clk_sys);
      end
      `CHK(n, len);
      `CHK(s, smp);
   endtask : measure
   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      cyc = 0;
      forever begin
         @(posedge i_clk_sys);
         cyc++;
         if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
         end
      end
   end
   initial begin
      {i_sel_wr, i_converter_enable_bit, i_free_running_bit, i_start_wr} = 4'h0;
      {i_done_clr, i_irq_en, i_cpu_halted} = 3'h0;
      i_channel_select_bits = CHAN_RESET;
      i_reference_select_bits = REF_RESET;
      i_sleep_mode = SLEEP_NONE;
      n_mismatch = 0;
      n_tests = 0;
      i_sys_rst = 1'b1;
      repeat (2) @(negedge i_clk_sys);
      i_sys_rst = 1'b0;
      `CHK({o_conversion_done_flag, o_conversion_start_bit, o_busy, o_result}, 13'h0000);
      i_converter_enable_bit = 1'b1;
      i_irq_en = 1'b1;
      for (int r = 0; r < 4; r++) begin
         wr_sel(4'h0, 2'(r));
         @(negedge i_clk_sys);
         `CHK(o_work_reference, 2'(r));
         `CHK(o_internal_ref_on, (2'(r) == REF_INTERNAL));
      end
      wr_sel(4'h3, REF_SUPPLY);
      start();
      measure(FIRST_CYCLES * DIV, (FIRST_SAMPLE + 1) * DIV);
      `CHK({o_conversion_done_flag, o_conversion_start_bit}, 2'h2);
      `CHK(o_result, exp_code(4'h3, REF_SUPPLY));
      `CHK(o_irq, 1'b1);
      clr();
      start();
      measure(NORMAL_CYCLES * DIV, (NORMAL_SAMPLE + 1) * DIV);
      clr();
      wr_sel(4'h2, REF_SUPPLY);
      start();
      repeat (3 * DIV) @(negedge i_clk_sys);
      wr_sel(4'hD, REF_INTERNAL);
      `CHK(o_channel_select_bits, 4'hD);
      `CHK(o_reference_select_bits, REF_INTERNAL);
      `CHK(o_work_channel, 4'h2);
      `CHK(o_work_reference, REF_SUPPLY);
      wait_done();
      `CHK(o_result, exp_code(4'h2, REF_SUPPLY));
      `CHK(o_work_channel, 4'hD);
      `CHK(o_work_reference, REF_INTERNAL);
      clr();
      start(); // first result after the reference switch is thrown away
      wait_done();
      clr();
      start();
      wait_done();
      `CHK(o_result, FULL_SCALE);
      clr();
      wr_sel(4'h1, REF_SUPPLY);
      i_free_running_bit = 1'b1;
      start();
      wait_done();
      `CHK({o_busy, o_conversion_start_bit}, 2'h3);
      wr_sel(4'h6, REF_SUPPLY);
      clr();
      wait_done();
      `CHK(o_result, exp_code(4'h1, REF_SUPPLY));
      clr();
      wait_done();
      `CHK(o_result, exp_code(4'h6, REF_SUPPLY));
      i_free_running_bit = 1'b0;
      wait_idle();
      clr();
      // converter enabled, idle, single mode, interrupt on before each halt
      for (int m = 0; m < 4; m++) begin
         i_sleep_mode = 2'(m);
         i_cpu_halted = 1'b1;
         repeat (2 * DIV + 2) @(negedge i_clk_sys);
         `CHK(o_busy, (m == 1 || m == 2));
         i_cpu_halted = 1'b0;
         wait_idle();
         `CHK(o_irq, (m == 1 || m == 2));
         clr();
      end
      i_cpu_halted = 1'b1;
      start();
      wait_done();
      `CHK(o_result, exp_code(4'h6, REF_SUPPLY));
      i_cpu_halted = 1'b0;
      clr();
      i_converter_enable_bit = 1'b0;
      repeat (2) @(negedge i_clk_sys);
      i_converter_enable_bit = 1'b1;
      start();
      measure(FIRST_CYCLES * DIV, (FIRST_SAMPLE + 1) * DIV);
      end_sim();
   end
endmodule : adcsc_top_test
